// ---- rtl/upvr_pkg.sv ----
// package for the vendor register bank: offsets, fields, resets, timing
package upvr_pkg;

  // --------------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------------
  localparam logic [5:0] ADDR_AMP_TRIM = 6'h31;
  localparam logic [5:0] ADDR_AUDIO_KEY = 6'h33;
  localparam logic [5:0] ADDR_CONV_WR = 6'h36;
  localparam logic [5:0] ADDR_CONV_SET = 6'h37;
  localparam logic [5:0] ADDR_CONV_CLR = 6'h38;
  localparam logic [5:0] ADDR_IOPM_WR = 6'h39;
  localparam logic [5:0] ADDR_IOPM_SET = 6'h3a;
  localparam logic [5:0] ADDR_IOPM_CLR = 6'h3b;

  // --------------------------------------------------------------------
  // field positions and masks
  // --------------------------------------------------------------------
  localparam int AMP_LSB = 5;
  localparam logic [7:0] AMP_MASK = 8'h60;
  localparam logic [7:0] KEY_MASK = 8'h0f;
  localparam logic [3:0] KEY_AUDIO_ON = 4'ha;
  localparam int CONV_DONE_BIT = 3;
  localparam int CONV_TRIG_BIT = 4;
  localparam int CONV_IRQ_EN_BIT = 6;
  localparam logic [7:0] CONV_WR_MASK = 8'h50;
  localparam int IOPM_SWAP_BIT = 1;
  localparam int IOPM_SER_LSB = 2;
  localparam int IOPM_PU_POS_BIT = 4;
  localparam int IOPM_PU_NEG_BIT = 5;
  localparam int IOPM_USB_LSB = 6;
  localparam logic [7:0] IOPM_MASK = 8'hfe;

  // --------------------------------------------------------------------
  // reset values and encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] AMP_RESET = 2'h0;
  localparam logic [3:0] KEY_RESET = 4'h0;
  localparam logic [7:0] IOPM_RESET = 8'h04;
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [1:0] LDO_3V3 = 2'h0;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_US = 282;
  localparam int CONV_CYCLES = (CONV_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
                               CONV_TIME_US * (CLK_HZ / 1_000_000) : 1;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
  } upvr_req_type;

  // operating mode of the transceiver
  typedef struct packed {
    logic uart_mode;
    logic usb_audio_mode;
    logic sync_mode;
    logic serial_mode;
    logic low_power_mode;
  } upvr_mode_type;

endpackage : upvr_pkg

// ---- rtl/upvr_bank.sv ----
// vendor register bank of the ulpi transceiver
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// (R01) amplitude field selects nominal or boosted drive
// (R02) reserved bits ignore writes, read zero
// (R03) audio mode only when key equals 1010
// (R04) three-bit code encodes measured id resistor
// (R05) done flag sets when conversion finishes
// (R06) done clears on vendor-register read only
// (R07) trigger starts conversion, self-clears at end
// (R08) link keeps conversion bit 5 zero
// (R09) enabled done flag raises alternate interrupt
// (R10) interrupt enable ORed with carkit enable
// (R11) conversion register write, set, clear addresses
// (R12) io power register write, set, clear addresses
// (R13) swap exchanges dp/dm, not audio pins
// (R14) serial ldo field applied in uart with txd
// (R15) usb audio holds regulator at 3.3 volts
// (R16) link should leave uart via reset pin
// (R17) pull-up bits, forced on in uart mode
// (R18) usb ldo field used in sync/serial/low-power
// (R19) carkit latch sets on enabled done rise
// (R20) vendor range reached by immediate accesses
// (R21) reset restores defaults, abandons conversion
module upvr_bank #(
  parameter int CONV_CYCLES_P = upvr_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire upvr_pkg::upvr_req_type req,
  input wire upvr_pkg::upvr_mode_type mode,
  input wire logic serial_tx_drive_enable,
  input wire logic carkit_irq_enable,
  input wire logic carkit_latch_rd,
  input wire logic [2:0] meas_code,
  output logic [7:0] rd_data,
  output logic [1:0] hs_amp_sel,
  output logic audio_mode_on,
  output logic [2:0] id_resistor_code,
  output logic id_conv_complete,
  output logic id_conv_busy,
  output logic alt_int,
  output logic id_conv_event_latch,
  output logic line_pair_swap,
  output logic line_pair_swap_dp,
  output logic charger_pullup_pos_line,
  output logic charger_pullup_neg_line,
  output logic [1:0] ldo_select
);
  import upvr_pkg::*;

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  logic [1:0] amp_reg;
  logic [3:0] key_reg;
  logic trig_reg;
  logic irq_en_reg;
  logic done_reg;
  logic [2:0] code_reg;
  logic [7:0] iopm_reg;
  logic [7:0] iopm_next;
  logic [31:0] cnt_reg;
  logic conv_end;
  logic conv_rd;
  logic irq_eff;
  logic [7:0] conv_view;
  logic [7:0] rd_next;
  logic [1:0] ldo_next;

  // conversion write accesses
  logic conv_wr;
  logic conv_set;
  logic conv_clr;
  logic [7:0] conv_wdata;
  assign conv_wr = req.wr && (req.addr == ADDR_CONV_WR); // R11
  assign conv_set = req.wr && (req.addr == ADDR_CONV_SET); // R11
  assign conv_clr = req.wr && (req.addr == ADDR_CONV_CLR); // R11
  assign conv_wdata = req.data & CONV_WR_MASK; // R08
  assign conv_rd = req.rd && (req.addr == ADDR_CONV_WR || req.addr == ADDR_CONV_SET ||
                              req.addr == ADDR_CONV_CLR);
  assign conv_end = trig_reg && (cnt_reg == 32'(CONV_CYCLES_P - 1));
  assign irq_eff = irq_en_reg | carkit_irq_enable; // R10

  // amplitude trim, only bits 6:5 stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_reg <= AMP_RESET; // R21
    end else if (req.wr && req.addr == ADDR_AMP_TRIM) begin
      amp_reg <= req.data[AMP_LSB +: 2]; // R01 R02 R20
    end
  end

  // headset audio key
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_reg <= KEY_RESET;
    end else if (req.wr && req.addr == ADDR_AUDIO_KEY) begin
      key_reg <= req.data[3:0]; // R02
    end
  end

  // interrupt enable bit of the conversion register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= 1'b0;
    end else if (conv_wr) begin
      irq_en_reg <= conv_wdata[CONV_IRQ_EN_BIT]; // R11
    end else if (conv_set && conv_wdata[CONV_IRQ_EN_BIT]) begin
      irq_en_reg <= 1'b1;
    end else if (conv_clr && conv_wdata[CONV_IRQ_EN_BIT]) begin
      irq_en_reg <= 1'b0;
    end
  end

  // trigger; completion clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_reg <= 1'b0; // R21
    end else if (conv_end) begin
      trig_reg <= 1'b0; // R07
    end else if (conv_wr) begin
      trig_reg <= conv_wdata[CONV_TRIG_BIT]; // R07
    end else if (conv_set && conv_wdata[CONV_TRIG_BIT]) begin
      trig_reg <= 1'b1; // R07
    end else if (conv_clr && conv_wdata[CONV_TRIG_BIT]) begin
      trig_reg <= 1'b0;
    end
  end

  // conversion timer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
    end else if (!trig_reg || conv_end) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1; // R05
    end
  end

  // result code and done flag; set beats read-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      code_reg <= CODE_RESET;
    end else if (conv_end) begin
      done_reg <= 1'b1; // R05
      code_reg <= meas_code; // R04
    end else if (conv_rd) begin
      done_reg <= 1'b0; // R06
    end
  end

  // carkit latch, set on enabled done rise, cleared by its read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_conv_event_latch <= 1'b0;
    end else if (conv_end && !done_reg && irq_eff) begin
      id_conv_event_latch <= 1'b1; // R19
    end else if (carkit_latch_rd) begin
      id_conv_event_latch <= 1'b0; // R19
    end
  end

  // io and power management write/set/clear
  always_comb begin
    iopm_next = iopm_reg;
    if (req.wr && req.addr == ADDR_IOPM_WR) begin
      iopm_next = req.data & IOPM_MASK; // R12
    end else if (req.wr && req.addr == ADDR_IOPM_SET) begin
      iopm_next = iopm_reg | (req.data & IOPM_MASK); // R12
    end else if (req.wr && req.addr == ADDR_IOPM_CLR) begin
      iopm_next = iopm_reg & ~(req.data & IOPM_MASK); // R12
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iopm_reg <= IOPM_RESET; // R21
    end else begin
      iopm_reg <= iopm_next;
    end
  end

  // --------------------------------------------------------------------
  // read mux and derived outputs
  // --------------------------------------------------------------------
  always_comb begin
    conv_view = 8'h00;
    conv_view[2:0] = code_reg;
    conv_view[CONV_DONE_BIT] = done_reg;
    conv_view[CONV_TRIG_BIT] = trig_reg;
    conv_view[CONV_IRQ_EN_BIT] = irq_en_reg;
    rd_next = 8'h00;
    unique case (req.addr)
      ADDR_AMP_TRIM: rd_next = {1'b0, amp_reg, 5'h00}; // R02
      ADDR_AUDIO_KEY: rd_next = {4'h0, key_reg}; // R02
      ADDR_CONV_WR, ADDR_CONV_SET, ADDR_CONV_CLR: rd_next = conv_view; // R11
      ADDR_IOPM_WR, ADDR_IOPM_SET, ADDR_IOPM_CLR: rd_next = iopm_reg; // R12
      default: rd_next = 8'h00;
    endcase
  end

  // regulator choice by mode
  always_comb begin
    ldo_next = iopm_reg[IOPM_USB_LSB +: 2]; // R18
    if (mode.usb_audio_mode) begin
      ldo_next = LDO_3V3; // R15
    end else if (mode.uart_mode && serial_tx_drive_enable) begin
      ldo_next = iopm_reg[IOPM_SER_LSB +: 2]; // R14
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      hs_amp_sel <= AMP_RESET;
      audio_mode_on <= 1'b0;
      id_resistor_code <= CODE_RESET;
      id_conv_complete <= 1'b0;
      id_conv_busy <= 1'b0;
      alt_int <= 1'b0;
      line_pair_swap <= 1'b0;
      line_pair_swap_dp <= 1'b0;
      charger_pullup_pos_line <= 1'b0;
      charger_pullup_neg_line <= 1'b0;
      ldo_select <= LDO_3V3;
    end else begin
      rd_data <= req.rd ? rd_next : 8'h00;
      hs_amp_sel <= amp_reg; // R01
      audio_mode_on <= (key_reg == KEY_AUDIO_ON); // R03
      id_resistor_code <= code_reg;
      id_conv_complete <= done_reg;
      id_conv_busy <= trig_reg;
      alt_int <= done_reg && irq_eff; // R09
      line_pair_swap <= iopm_reg[IOPM_SWAP_BIT];
      line_pair_swap_dp <= iopm_reg[IOPM_SWAP_BIT]; // R13
      charger_pullup_pos_line <= iopm_reg[IOPM_PU_POS_BIT] | mode.uart_mode; // R17
      charger_pullup_neg_line <= iopm_reg[IOPM_PU_NEG_BIT] | mode.uart_mode; // R17
      ldo_select <= ldo_next;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  audio_key_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R03
    audio_mode_on == ($past(key_reg) == KEY_AUDIO_ON))
    else $error("audio mode does not follow key");

  done_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R05
    conv_end |=> done_reg && !trig_reg)
    else $error("done not set at conversion end");

  done_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R06
    (conv_rd && !conv_end) |=> !done_reg)
    else $error("done not cleared by read");

  conv_len_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R07
    $rose(trig_reg) && !conv_end |-> trig_reg [*8])
    else $error("conversion ended too early");

  irq_or_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    (done_reg && (irq_en_reg || carkit_irq_enable)) |=> alt_int)
    else $error("alternate interrupt missing");

  iopm_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    (req.wr && req.addr == ADDR_IOPM_SET) |=> ((iopm_reg & $past(req.data) & IOPM_MASK) ==
                                              ($past(req.data) & IOPM_MASK)))
    else $error("set access lost a bit");

  audio_ldo_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
    mode.usb_audio_mode |=> ldo_select == LDO_3V3)
    else $error("regulator not at 3.3 volts in audio mode");

  pullup_uart_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
    mode.uart_mode |=> charger_pullup_pos_line && charger_pullup_neg_line)
    else $error("uart pull-ups not enabled");

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R02
    $past(req.rd) && $past(req.addr) == ADDR_AMP_TRIM |-> (rd_data & ~AMP_MASK) == 8'h00)
    else $error("reserved amplitude bits not zero");

  // per-field guards on writes, captures and derived outputs
  amp_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R01
    (req.wr && req.addr == ADDR_AMP_TRIM) |=> ##1 hs_amp_sel == $past(req.data[AMP_LSB +: 2], 2))
    else $error("amplitude select does not follow write");

  key_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R02
    $past(req.rd) && $past(req.addr) == ADDR_AUDIO_KEY |-> rd_data[7:4] == 4'h0)
    else $error("reserved key bits not zero");

  code_capture_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R04
    conv_end |=> code_reg == $past(meas_code))
    else $error("result code not captured at conversion end");

  trig_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R07
    (conv_set && conv_wdata[CONV_TRIG_BIT] && !conv_end) |=> trig_reg)
    else $error("set access did not start conversion");

  alt_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R09
    !done_reg |=> !alt_int)
    else $error("alternate interrupt without done flag");

  irq_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    (conv_clr && req.data[CONV_IRQ_EN_BIT]) |=> !irq_en_reg)
    else $error("clear access left interrupt enable set");

  iopm_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    (req.wr && req.addr == ADDR_IOPM_CLR) |=> (iopm_reg & $past(req.data) & IOPM_MASK) == 8'h00)
    else $error("clear access left a bit set");

  swap_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
    line_pair_swap_dp == $past(iopm_reg[IOPM_SWAP_BIT]))
    else $error("line swap does not follow its bit");

  serial_ldo_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
    (mode.uart_mode && serial_tx_drive_enable && !mode.usb_audio_mode) |=>
      ldo_select == $past(iopm_reg[IOPM_SER_LSB +: 2]))
    else $error("serial regulator field not applied");

  pullup_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
    !mode.uart_mode |=> charger_pullup_pos_line == $past(iopm_reg[IOPM_PU_POS_BIT]))
    else $error("pull-up does not follow its bit");

  usb_ldo_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
    (!mode.usb_audio_mode && !(mode.uart_mode && serial_tx_drive_enable) &&
     (mode.sync_mode || mode.serial_mode || mode.low_power_mode)) |=>
      ldo_select == $past(iopm_reg[IOPM_USB_LSB +: 2]))
    else $error("usb regulator field not applied");

  latch_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    (conv_end && !done_reg && irq_eff) |=> id_conv_event_latch)
    else $error("carkit latch not set on done rise");

  latch_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    (carkit_latch_rd && !(conv_end && !done_reg && irq_eff)) |=> !id_conv_event_latch)
    else $error("carkit latch not cleared by its read");

endmodule : upvr_bank

`default_nettype wire

// ---- tb/upvr_link_model.sv ----
// link controller model issuing immediate register accesses
`timescale 1ns/10ps
`default_nettype none
module upvr_link_model (
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  output var upvr_pkg::upvr_req_type req
);
  import upvr_pkg::*;
  initial req = '0;
  // write, set or clear; idle bus shows inverted address and data
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a inside {ADDR_CONV_WR, ADDR_CONV_SET, ADDR_CONV_CLR}) v[5] = 1'b0;
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~v};
  endtask : wr
  // read; data taken in the cycle after the accepting edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
    @(negedge core_clk);
    d = rd_data;
  endtask : rd
endmodule : upvr_link_model
`default_nettype wire

// ---- tb/upvr_bank_tb.sv ----
// self-checking bench for the vendor register bank
`timescale 1ns/10ps
`default_nettype none
module upvr_bank_tb;
  import upvr_pkg::*;
  logic core_clk, rst_n, txd, ck_en, ck_rd, amode, swap_dp, busy, done, aint, latch;
  logic swap, pu_p, pu_n;
  logic [2:0] meas, code;
  logic [1:0] amp, ldo;
  logic [7:0] rdata, v;
  upvr_req_type req;
  upvr_mode_type mode;
  int err_total, n_tests;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
  upvr_bank #(.CONV_CYCLES_P(10)) dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .mode(mode), .serial_tx_drive_enable(txd), .carkit_irq_enable(ck_en),
    .carkit_latch_rd(ck_rd), .meas_code(meas), .rd_data(rdata), .hs_amp_sel(amp),
    .audio_mode_on(amode), .id_resistor_code(code), .id_conv_complete(done),
    .id_conv_busy(busy), .alt_int(aint), .id_conv_event_latch(latch),
    .line_pair_swap(swap), .line_pair_swap_dp(swap_dp), .charger_pullup_pos_line(pu_p),
    .charger_pullup_neg_line(pu_n), .ldo_select(ldo));
  upvr_link_model link (.core_clk(core_clk), .rd_data(rdata), .req(req));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // let registered mirrors follow the last access
  task automatic settle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  // bounded wait for the done flag
  task automatic wait_done();
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge core_clk);
    if (done !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask : wait_done
  task automatic t_defaults();
    link.rd(6'h31, v); `CHK(v, 8'h00)
    link.rd(6'h33, v); `CHK(v, 8'h00)
    link.rd(6'h36, v); `CHK(v, 8'h00)
    link.rd(6'h39, v); `CHK(v, 8'h04)
    `CHK(ldo, 2'h0)
    link.wr(6'h30, 8'hff); link.rd(6'h30, v); `CHK(v, 8'h00)
  endtask : t_defaults
  task automatic t_amp_key();
    for (int c = 0; c < 4; c++) begin
      link.wr(6'h31, {1'b1, 2'(c), 5'h1f}); settle(); `CHK(amp, 2'(c))
      link.rd(6'h31, v); `CHK(v, {1'b0, 2'(c), 5'h00})
    end
    link.wr(6'h33, 8'hfa); settle(); `CHK(amode, 1'b1)
    link.rd(6'h33, v); `CHK(v, 8'h0a)
    link.wr(6'h33, 8'h0b); settle(); `CHK(amode, 1'b0)
  endtask : t_amp_key
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      @(posedge core_clk);
      meas <= 3'(c);
      link.wr(6'h37, 8'h10); repeat (3) @(negedge core_clk);
      `CHK({busy, done}, 2'b10)
      wait_done(); `CHK(code, 3'(c))
      `CHK(aint, 1'b0)
      link.rd(6'h36, v); `CHK(v, {5'h01, 3'(c)})
      link.rd(6'h38, v); `CHK(v, {5'h00, 3'(c)})
    end
  endtask : t_codes
  task automatic t_irq();
    link.wr(6'h36, 8'h70); wait_done(); settle();
    `CHK({aint, latch}, 2'b11)
    @(posedge core_clk);
    ck_rd <= 1'b1; @(posedge core_clk); ck_rd <= 1'b0; settle();
    `CHK(latch, 1'b0)
    link.rd(6'h37, v); settle(); `CHK({aint, done}, 2'b00)
    link.wr(6'h38, 8'h40); ck_en <= 1'b1; link.wr(6'h37, 8'h10); wait_done(); settle();
    `CHK({aint, latch}, 2'b11)
    @(posedge core_clk);
    ck_en <= 1'b0; settle(); `CHK(aint, 1'b0)
    link.rd(6'h36, v); `CHK(v, 8'h0f)
  endtask : t_irq
  task automatic t_iopm();
    link.wr(6'h39, 8'hff); link.rd(6'h39, v); `CHK(v, 8'hfe)
    link.wr(6'h3b, 8'hff); link.rd(6'h3a, v); `CHK(v, 8'h00)
    link.wr(6'h3a, 8'h12); link.rd(6'h3b, v); `CHK(v, 8'h12)
    settle(); `CHK({swap, swap_dp, pu_p, pu_n}, 4'b1110)
    link.wr(6'h39, 8'h4c); mode.uart_mode <= 1'b1; settle();
    `CHK({pu_p, pu_n, ldo}, 4'b1101)
    @(posedge core_clk);
    txd <= 1'b1; settle(); `CHK(ldo, 2'h3)
    @(posedge core_clk);
    mode.usb_audio_mode <= 1'b1; settle(); `CHK(ldo, 2'h0)
    @(posedge core_clk);
    mode <= '{sync_mode: 1'b1, default: 1'b0}; txd <= 1'b0; settle(); `CHK(ldo, 2'h1)
  endtask : t_iopm
  // reset in mid-conversion, also the way out of uart mode
  task automatic t_reset();
    link.wr(6'h36, 8'h10); mode.uart_mode <= 1'b1; repeat (3) @(posedge core_clk);
    rst_n <= 1'b0; mode <= '0; repeat (2) @(posedge core_clk); rst_n <= 1'b1;
    settle(); `CHK({busy, done, ldo}, 4'b0000)
    link.rd(6'h39, v); `CHK(v, 8'h04)
  endtask : t_reset
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0; txd = 1'b0; ck_en = 1'b0; ck_rd = 1'b0; meas = 3'h0; mode = '0;
    err_total = 0; n_tests = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_defaults(); t_amp_key(); t_codes(); t_irq(); t_iopm(); t_reset();
    complete_run();
  end
endmodule : upvr_bank_tb
`default_nettype wire
